/* File: core/ppvc_pkg.sv */
// Package: register map, field layout, reset values and timing of port power
package ppvc_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] MASK_OFF = 8'h08;
   localparam logic [7:0] LIVE_OFF = 8'h0C;

   // Control register fields
   localparam int CTRL_PORT_EN_LSB = 0;
   localparam int CTRL_SPLIT_BIT = 4;
   localparam int CTRL_SS_EN_BIT = 5;
   localparam int CTRL_VCONN_LSB = 8;

   // Status, mask and live register fields
   localparam int STAT_OC_LSB = 0;
   localparam int STAT_VFAULT_LSB = 4;
   localparam int LIVE_OCS_LSB = 0;
   localparam int LIVE_CC_LSB = 4;
   localparam int LIVE_DISCH_LSB = 8;

   // Reset values
   localparam logic [3:0] PORT_EN_RST = 4'h0;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] SYNC_RST = 8'h0F;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int DISCH_TIME_NS = 1000;
   localparam int SETTLE_TIME_NS = 100;
   localparam logic [7:0] DISCH_CYCLES =
      8'((DISCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] SETTLE_CYCLES =
      4'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ppvc_bus_req_t;

endpackage

/* File: core/ppvc_sync.sv */
// Three-stage input synchroniser with second/third stage agreement
`timescale 1ns/100ps
module ppvc_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] level_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
   } ppvc_sync_state_t;

   ppvc_sync_state_t s_r;
   ppvc_sync_state_t s_nxt;

   // Shift chain; the accepted level moves only when stages two and three agree
   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = async_i;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      for (int i = 0; i < W; i++) begin
         if (s_r.s2[i] == s_r.s3[i]) begin
            s_nxt.level[i] = s_r.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s_r <= {RST, RST, RST, RST};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign level_o = s_r.level;

endmodule // ppvc_sync

/* File: core/ppvc_port_power.sv */
// Downstream port power, overcurrent sense and connector supply control
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps

module ppvc_port_power #(
   parameter logic [7:0] DISCH_CYCLES = ppvc_pkg::DISCH_CYCLES,
   parameter logic [3:0] SETTLE_CYCLES = ppvc_pkg::SETTLE_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire ppvc_pkg::ppvc_bus_req_t bus_i,
   output logic [31:0] rdata_o,
   input wire logic [3:0] port_power_ocs_i,
   output logic [3:0] port_power_ocs_o,
   output logic [3:0] port_power_ocs_oe_n_o,
   output logic [3:0] port_power_pullup_o,
   input wire logic [3:0] cc_above_3v_i,
   output logic [3:0] cc_supply_en_o,
   output logic [1:0] bus_discharge_o,
   output logic port3_superspeed_power_en_o,
   output logic irq_o
);

   typedef struct packed {
      logic [3:0] port_en;
      logic split_mode;
      logic ss_en;
      logic [3:0] vconn_req;
      logic [7:0] status;
      logic [7:0] mask;
      logic [3:0] pin_out;
      logic [3:0] pin_oe_n;
      logic [3:0] pull_en;
      logic [3:0] vconn_en;
      logic [1:0] disch;
      logic [1:0][7:0] disch_cnt;
      logic [7:0][3:0] settle;
      logic ss_pwr;
      logic irq;
      logic [31:0] rdata;
   } ppvc_state_t;

   ppvc_state_t s_r;
   ppvc_state_t s_nxt;
   logic [7:0] sync_level;
   logic [3:0] ocs_level;
   logic [3:0] cc_level;

   // Address match of a bus request against one register offset
   function automatic logic reg_hit(input logic [7:0] addr,
                                    input logic [7:0] off);
      reg_hit = (addr == off);
   endfunction

   // Pin and comparator inputs come from outside the clock domain
   ppvc_sync #(
      .W(8),
      .RST(ppvc_pkg::SYNC_RST)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .async_i({cc_above_3v_i, port_power_ocs_i}),
      .level_o(sync_level)
   );

   assign ocs_level = sync_level[3:0];
   assign cc_level = sync_level[7:4];

   // Next-state logic for configuration, pins, faults and register reads
   always_comb begin
      logic [7:0] watch;
      logic [7:0] fault_lvl;
      logic [7:0] events;
      logic [7:0] w1c;
      watch = '0;
      fault_lvl = '0;
      events = '0;
      w1c = '0;
      s_nxt = s_r;

      // Control register write: port enables, split mode, supply requests
      if (bus_i.wr && reg_hit(bus_i.addr, ppvc_pkg::CTRL_OFF)) begin
         s_nxt.port_en = bus_i.wdata[ppvc_pkg::CTRL_PORT_EN_LSB +: 4];
         s_nxt.split_mode = bus_i.wdata[ppvc_pkg::CTRL_SPLIT_BIT];
         s_nxt.ss_en = bus_i.wdata[ppvc_pkg::CTRL_SS_EN_BIT];
         s_nxt.vconn_req = bus_i.wdata[ppvc_pkg::CTRL_VCONN_LSB +: 4];
      end

      // Mask register write
      if (bus_i.wr && reg_hit(bus_i.addr, ppvc_pkg::MASK_OFF)) begin
         s_nxt.mask = bus_i.wdata[7:0];
      end

      // Enabled port releases pin with pull-up
      s_nxt.pull_en = s_r.port_en;
      s_nxt.pin_oe_n = s_r.port_en;
      s_nxt.pin_out = 4'h0;

      // One pin per port for ports 1, 2 and 4; port 3 also
      // covers superspeed unless split mode hands that off
      // Split mode drives the separate superspeed enable
      s_nxt.ss_pwr = s_r.split_mode & s_r.ss_en;

      // Connector supply enables, forced off while the port is disabled
      for (int t = 0; t < 2; t++) begin
         s_nxt.vconn_en[2*t] = s_r.vconn_req[2*t] & s_r.port_en[t];
         s_nxt.vconn_en[2*t+1] = s_r.vconn_req[2*t+1] & s_r.port_en[t];
      end

      // Discharge pulse when a Type-C port loses bus power
      for (int t = 0; t < 2; t++) begin
         if (s_r.port_en[t]) begin
            // Power coming back: a running strobe must stop at once
            s_nxt.disch_cnt[t] = 8'h00;
         end else if (s_r.pull_en[t]) begin
            s_nxt.disch_cnt[t] = DISCH_CYCLES;
         end else if (s_r.disch_cnt[t] != 8'h00) begin
            s_nxt.disch_cnt[t] = s_r.disch_cnt[t] - 8'h01;
         end
         s_nxt.disch[t] = (s_nxt.disch_cnt[t] != 8'h00);
      end

      // Fault watchers: low four are power pins, high four are CC lines
      watch = {s_r.vconn_en, s_r.pull_en};
      fault_lvl[3:0] = ~ocs_level;
      // Supply on but CC not above 3V
      fault_lvl[7:4] = ~cc_level;

      // Each watcher waits a settle time after it is armed
      for (int i = 0; i < 8; i++) begin
         if (!watch[i]) begin
            s_nxt.settle[i] = SETTLE_CYCLES;
         end else if (s_r.settle[i] != 4'h0) begin
            s_nxt.settle[i] = s_r.settle[i] - 4'h1;
         end
         events[i] = watch[i] && (s_r.settle[i] == 4'h0) && fault_lvl[i];
      end

      // Sticky status, set wins over clear
      if (bus_i.wr && reg_hit(bus_i.addr, ppvc_pkg::STATUS_OFF)) begin
         w1c = bus_i.wdata[7:0];
      end
      s_nxt.status = (s_r.status & ~w1c) | events;

      // Level interrupt from unmasked status bits
      s_nxt.irq = |(s_nxt.status & s_nxt.mask);

      // Read data stand for the single cycle after the read strobe
      s_nxt.rdata = 32'h0000_0000;
      if (bus_i.rd) begin
         if (reg_hit(bus_i.addr, ppvc_pkg::CTRL_OFF)) begin
            s_nxt.rdata[ppvc_pkg::CTRL_PORT_EN_LSB +: 4] = s_r.port_en;
            s_nxt.rdata[ppvc_pkg::CTRL_SPLIT_BIT] = s_r.split_mode;
            s_nxt.rdata[ppvc_pkg::CTRL_SS_EN_BIT] = s_r.ss_en;
            s_nxt.rdata[ppvc_pkg::CTRL_VCONN_LSB +: 4] = s_r.vconn_req;
         end else if (reg_hit(bus_i.addr, ppvc_pkg::STATUS_OFF)) begin
            s_nxt.rdata[7:0] = s_r.status;
         end else if (reg_hit(bus_i.addr, ppvc_pkg::MASK_OFF)) begin
            s_nxt.rdata[7:0] = s_r.mask;
         end else if (reg_hit(bus_i.addr, ppvc_pkg::LIVE_OFF)) begin
            s_nxt.rdata[ppvc_pkg::LIVE_OCS_LSB +: 4] = ocs_level;
            s_nxt.rdata[ppvc_pkg::LIVE_CC_LSB +: 4] = cc_level;
            s_nxt.rdata[ppvc_pkg::LIVE_DISCH_LSB +: 2] = s_r.disch;
         end
      end
   end

   // State register; reset leaves every port disabled with pins driven low
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s_r <= '0;
         s_r.port_en <= ppvc_pkg::PORT_EN_RST;
         s_r.mask <= ppvc_pkg::MASK_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign rdata_o = s_r.rdata;
   assign port_power_ocs_o = s_r.pin_out;
   assign port_power_ocs_oe_n_o = s_r.pin_oe_n;
   assign port_power_pullup_o = s_r.pull_en;
   assign cc_supply_en_o = s_r.vconn_en;
   assign bus_discharge_o = s_r.disch;
   assign port3_superspeed_power_en_o = s_r.ss_pwr;
   assign irq_o = s_r.irq;

endmodule // ppvc_port_power

/* File: tb/ppvc_switch_model.sv */
// Model of the external power switches, monitors and CC comparators
`timescale 1ns/100ps
module ppvc_switch_model (
   input wire logic [3:0] drive_i,
   input wire logic [3:0] oe_n_i,
   input wire logic [3:0] pullup_i,
   input wire logic [3:0] oc_i,
   input wire logic [3:0] supply_en_i,
   input wire logic [3:0] cc_bad_i,
   input wire logic ss_en_i,
   output logic [3:0] pin_o,
   output logic [3:0] cc_o,
   output logic embedded_pwr_o
);
   // Pin level from device drive, pull-up and current monitor
   // Released pin pulls up
   assign pin_o = (~oe_n_i & drive_i) | (oe_n_i & pullup_i & ~oc_i);
   // CC sensed above 3.0V only with supply on and a sound cable
   // Wired supply sets CC
   assign cc_o = supply_en_i & ~cc_bad_i;
   // Separate superspeed enable feeds the on-board device alone
   // Embedded device power only
   assign embedded_pwr_o = ss_en_i;
endmodule // ppvc_switch_model

/* File: tb/ppvc_port_power_props.sv */
// Checker of power pins, supply enables, discharge and interrupt
`timescale 1ns/100ps
module ppvc_port_power_props #(
   parameter logic [7:0] DISCH_CYCLES = ppvc_pkg::DISCH_CYCLES,
   parameter logic [3:0] SETTLE_CYCLES = ppvc_pkg::SETTLE_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire ppvc_pkg::ppvc_bus_req_t bus_i,
   input wire logic [3:0] port_power_ocs_o,
   input wire logic [3:0] port_power_ocs_oe_n_o,
   input wire logic [3:0] port_power_pullup_o,
   input wire logic [3:0] cc_supply_en_o,
   input wire logic [1:0] bus_discharge_o,
   input wire logic port3_superspeed_power_en_o,
   input wire logic irq_o
);
   logic [3:0] tc_en;
   logic [7:0] len_r;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   // Supply enables may only be high where their port is powered
   assign tc_en = {{2{port_power_ocs_oe_n_o[1]}},
                   {2{port_power_ocs_oe_n_o[0]}}};
   // Length of the running port 1 discharge strobe
   always_ff @(posedge core_clk_i) begin
      len_r <= (reset_i || !bus_discharge_o[0]) ? 8'h00 : len_r + 8'h01;
   end
   sequence ctrl_wr;
      bus_i.wr && bus_i.addr == ppvc_pkg::CTRL_OFF;
   endsequence
   pin_low_a: assert property (port_power_ocs_o == 4'h0)
      else $error("power pin drive not low");
   pullup_oe_a: assert property (
      port_power_pullup_o == port_power_ocs_oe_n_o)
      else $error("pull-up and pin direction differ");
   pin_follow_a: assert property (
      ctrl_wr |-> ##2 port_power_ocs_oe_n_o == $past(bus_i.wdata[3:0], 2))
      else $error("pin direction does not follow port enable");
   supply_gate_a: assert property (
      (cc_supply_en_o & ~tc_en) == 4'h0)
      else $error("supply enable on a disabled port");
   ss_off_a: assert property (
      ctrl_wr ##0 !bus_i.wdata[4] |-> ##2 !port3_superspeed_power_en_o)
      else $error("superspeed enable high with split off");
   ss_on_a: assert property (
      ctrl_wr ##0 bus_i.wdata[5:4] == 2'b11 |-> ##2 port3_superspeed_power_en_o)
      else $error("superspeed enable low with split on");
   disch_idle_a: assert property (
      (bus_discharge_o & port_power_ocs_oe_n_o[1:0]) == 2'b00)
      else $error("discharge on a powered port");
   disch_start_a: assert property (
      $fell(port_power_ocs_oe_n_o[0]) |=> bus_discharge_o[0])
      else $error("discharge did not start");
   disch_len_a: assert property (
      $fell(bus_discharge_o[0]) && !port_power_ocs_oe_n_o[0]
      |-> len_r == DISCH_CYCLES)
      else $error("discharge strobe length wrong");
   disch_stop_a: assert property (
      $rose(port_power_ocs_oe_n_o[0]) |-> !bus_discharge_o[0])
      else $error("discharge still on after power returned");
   irq_mask_a: assert property (
      bus_i.wr && bus_i.addr == ppvc_pkg::MASK_OFF && bus_i.wdata[7:0] == 8'h00
      |=> !irq_o)
      else $error("interrupt high with all masked");
endmodule // ppvc_port_power_props
bind ppvc_port_power ppvc_port_power_props #(
   .DISCH_CYCLES(DISCH_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)
) u_props (.core_clk_i, .reset_i, .bus_i, .port_power_ocs_o,
   .port_power_ocs_oe_n_o, .port_power_pullup_o, .cc_supply_en_o,
   .bus_discharge_o, .port3_superspeed_power_en_o, .irq_o);

/* File: tb/port_power_vconn_control_tb.sv */
// Self-checking bench of the port power and connector supply block
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
   $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module port_power_vconn_control_tb;
   localparam logic [7:0] DISCH = 8'h03;
   logic core_clk_i;
   logic reset_i;
   ppvc_pkg::ppvc_bus_req_t bus;
   logic [31:0] rdata;
   logic [3:0] pin, drv, oe_n, pu, oc, cc_en, cc_bad, cc;
   logic [1:0] disch;
   logic ss, irq, emb;
   int n_fail, check_count, cyc, d1, d2;
   // Rows: control word, pin direction, supply enables, superspeed
   logic [23:0] rows [6] = '{24'h00_0000, 24'hF0_FFF0, 24'hF0_5530,
                             24'h03_AA01, 24'hC0_22C0, 24'h01_0000};
   ppvc_port_power #(.DISCH_CYCLES(DISCH), .SETTLE_CYCLES(4'h4)) DUT (
      .core_clk_i, .reset_i, .bus_i(bus), .rdata_o(rdata),
      .port_power_ocs_i(pin), .port_power_ocs_o(drv),
      .port_power_ocs_oe_n_o(oe_n), .port_power_pullup_o(pu),
      .cc_above_3v_i(cc), .cc_supply_en_o(cc_en), .bus_discharge_o(disch),
      .port3_superspeed_power_en_o(ss), .irq_o(irq));
   ppvc_switch_model u_sw (.drive_i(drv), .oe_n_i(oe_n), .pullup_i(pu),
      .oc_i(oc), .supply_en_i(cc_en), .cc_bad_i(cc_bad), .pin_o(pin),
      .cc_o(cc), .ss_en_i(ss), .embedded_pwr_o(emb));
   task automatic t(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      t(1);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      t(1);
      bus.wr <= 1'b0;
   endtask
   // Read, then compare the word in the following cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      t(1);
      bus.addr <= a;
      bus.rd <= 1'b1;
      t(1);
      bus.rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // Cycle ceiling against hangs
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      reset_i = 1'b1;
      bus = '0;
      oc = 4'h0;
      cc_bad = 4'h0;
      t(16);
      reset_i <= 1'b0;
      t(1);
      #1 `CHK({oe_n, pu, cc_en, disch, irq}, 15'h0000)
      foreach (rows[i]) begin
         wr(ppvc_pkg::CTRL_OFF, {20'h0_0000, rows[i][23:12]});
         t(2);
         #1 `CHK({oe_n, pu}, {2{rows[i][11:8]}})
         `CHK({cc_en, emb}, {rows[i][7:4], rows[i][0]})
      end
      // Overcurrent on port 3: sticky status, interrupt, clear
      wr(ppvc_pkg::MASK_OFF, 32'h0000_00FF);
      wr(ppvc_pkg::STATUS_OFF, 32'h0000_00FF);
      wr(ppvc_pkg::CTRL_OFF, 32'h0000_000F);
      t(20);
      oc <= 4'h4;
      t(10);
      rd(ppvc_pkg::STATUS_OFF, 32'h0000_0004);
      `CHK(irq, 1'b1)
      oc <= 4'h0;
      t(10);
      rd(ppvc_pkg::STATUS_OFF, 32'h0000_0004);
      wr(ppvc_pkg::STATUS_OFF, 32'h0000_00FF);
      rd(ppvc_pkg::STATUS_OFF, 32'h0000_0000);
      `CHK(irq, 1'b0)
      // Supply fault on port 1 CC1; low pin on disabled port 4 ignored
      wr(ppvc_pkg::CTRL_OFF, 32'h0000_0107);
      cc_bad <= 4'h1;
      oc <= 4'h8;
      t(20);
      rd(ppvc_pkg::STATUS_OFF, 32'h0000_0010);
      rd(ppvc_pkg::LIVE_OFF, 32'h0000_0007);
      rd(ppvc_pkg::CTRL_OFF, 32'h0000_0107);
      rd(ppvc_pkg::MASK_OFF, 32'h0000_00FF);
      // Disabling both Type-C ports gives one short discharge each
      wr(ppvc_pkg::CTRL_OFF, 32'h0000_0000);
      repeat (10) begin
         t(1);
         #1 d1 += int'(disch[0]);
         d2 += int'(disch[1]);
      end
      `CHK({d1[7:0], d2[7:0]}, {DISCH, DISCH})
      // Power restored in mid-strobe: the strobe stops at once
      wr(ppvc_pkg::CTRL_OFF, 32'h0000_0003);
      t(10);
      wr(ppvc_pkg::CTRL_OFF, 32'h0000_0000);
      wr(ppvc_pkg::CTRL_OFF, 32'h0000_0003);
      t(1);
      #1 `CHK(disch, 2'b00)
      wr(ppvc_pkg::MASK_OFF, 32'h0000_0000);
      #1 `CHK(irq, 1'b0)
      t(2);
      summarize();
   end
endmodule // port_power_vconn_control_tb
